//--- csis_core_seq.sv
`timescale 1ns/1ps
// Summary of operation
// (RULE_01) Push stores at the pointer then lowers it by one; pop raises by one.
// (RULE_02) Calls and interrupt entry lower the pointer by two; returns raise by two.
// (RULE_03) Pointer kept as low and high I/O bytes, eleven bits in all.
// (RULE_04) Pointer starts at last SRAM word; software moves it before use.
// (RULE_05) Register or immediate ALU operation reads, computes and writes in one cycle.
// (RULE_06) Core runs straight on the CPU clock, no divider.
// (RULE_07) Next instruction fetched while current executes, one per clock.
// (RULE_08) Source taken only with its own enable and global enable set.
// (RULE_09) Programmed boot lock fields block interrupts depending on program counter.
// (RULE_10) Vectors at lowest addresses; lower address means higher priority.
// (RULE_11) Vector select moves vectors, boot reset fuse moves reset, to boot start.
// (RULE_12) Taking an interrupt clears global enable.
// (RULE_13) Handler may set global enable again, allowing nesting.
// (RULE_14) Interrupt return sets global enable.
// (RULE_15) Taking a flag interrupt clears that flag in hardware.
// (RULE_16) Writing one to a flag clears it; zero leaves it.
// (RULE_17) Flags stay pending while disabled, then served by priority.
// (RULE_18) Level sources request only while their condition is present.
// (RULE_19) After interrupt return one main instruction runs before the next interrupt.
// (RULE_20) Software saves and restores the status register in handlers.
// (RULE_21) Global disable blocks at once, even an interrupt in the same cycle.
// (RULE_22) The instruction after global enable runs before any pending interrupt.
// (RULE_23) Interrupt response takes four cycles, four more when waking from sleep.
// (RULE_24) Interrupt return takes four cycles, pops two bytes, sets global enable.
// (RULE_25) Interrupt during a multi-cycle instruction waits until it completes.
// (RULE_26) Unused high pointer bits read zero and ignore writes.
module csis_core_seq #(
  parameter int N_SRC = 8,
  parameter int IDX_W = 3
) (
  input wire logic mclk, // [RULE_06]
  input wire logic rst_n,
  input wire logic [5:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata_ff,
  input wire logic instr_valid,
  input wire logic instr_last,
  input wire csis_pkg::csis_op_t instr_op,
  input wire logic [7:0] instr_data,
  input wire logic [csis_pkg::PC_W-1:0] instr_target,
  input wire csis_pkg::csis_alu_t alu_fn,
  input wire logic [4:0] alu_rd,
  input wire logic [4:0] alu_rr,
  input wire logic [7:0] alu_imm,
  input wire logic alu_use_imm,
  input wire logic sleeping,
  input wire logic vector_select_bit,
  input wire logic boot_reset_fuse,
  input wire logic app_lock_field,
  input wire logic boot_lock_field,
  input wire logic [N_SRC-1:0] flag_evt,
  input wire logic [N_SRC-1:0] level_type,
  input wire logic [N_SRC-1:0] level_req,
  input wire logic [N_SRC-1:0] src_enable,
  input wire logic flag_clr_wr,
  input wire logic [N_SRC-1:0] flag_clr_data,
  output logic [csis_pkg::PC_W-1:0] fetch_pc_ff,
  output logic busy_ff,
  output logic gie_ff,
  output logic stk_we_ff,
  output logic stk_rd_ff,
  output logic [csis_pkg::SP_W-1:0] stk_addr_ff,
  output logic [7:0] stk_wdata_ff,
  input wire logic [7:0] stk_rdata,
  output logic [7:0] alu_result_ff
);

  localparam int PW = csis_pkg::PC_W;
  localparam int SW = csis_pkg::SP_W;

  // ==========================================================
  // Interrupt source bank
  csis_irq_if #(.N_SRC(N_SRC), .IDX_W(IDX_W)) irq ();

  csis_irq_bank #(.N_SRC(N_SRC), .IDX_W(IDX_W)) u_bank (
    .mclk(mclk),
    .rst_n(rst_n),
    .flag_evt(flag_evt),
    .level_type(level_type),
    .level_req(level_req),
    .src_enable(src_enable),
    .flag_clr_wr(flag_clr_wr),
    .flag_clr_data(flag_clr_data),
    .irq(irq)
  );

  // ==========================================================
  // State
  csis_pkg::csis_state_t state_ff;
  csis_pkg::csis_state_t nxt_state;
  logic [1:0] cnt_ff;
  logic [SW-1:0] sp_ff;
  logic [PW-1:0] pc_ff;
  logic [PW-1:0] ret_pc_ff;
  logic [PW-1:0] target_ff;
  logic [7:0] hi_ff;
  logic is_irq_ff;
  logic hold_ff;
  logic [7:0] rf [32];

  // ==========================================================
  // Instruction decode
  logic in_run;
  logic boundary;
  logic do_push;
  logic do_pop;
  logic do_call;
  logic do_ret;
  logic do_iret;
  logic do_sei;
  logic do_alu;
  logic cli_now;
  logic flow_op;

  assign in_run = (state_ff == csis_pkg::ST_RUN);
  // Multi-cycle instructions only end on their last cycle
  assign boundary = in_run && instr_valid && instr_last; // [RULE_25]
  assign do_push = boundary && instr_op == csis_pkg::OP_PUSH;
  assign do_pop = boundary && instr_op == csis_pkg::OP_POP;
  assign do_call = boundary && instr_op == csis_pkg::OP_CALL;
  assign do_ret = boundary && instr_op == csis_pkg::OP_RET;
  assign do_iret = boundary && instr_op == csis_pkg::OP_IRET;
  assign do_sei = boundary && instr_op == csis_pkg::OP_SEI;
  assign do_alu = in_run && instr_valid && instr_op == csis_pkg::OP_ALU;
  assign cli_now = in_run && instr_valid && instr_op == csis_pkg::OP_CLI;
  assign flow_op = do_call || do_ret || do_iret;

  // ==========================================================
  // Interrupt acceptance
  logic pc_in_boot;
  logic lock_block;
  logic take_ok;
  logic take_run;
  logic take_sleep;
  logic take;
  logic [PW-1:0] vec_base;
  logic [PW-1:0] vec_addr;

  assign pc_in_boot = (pc_ff >= csis_pkg::BOOT_START);
  assign lock_block = (!pc_in_boot && vector_select_bit && app_lock_field)
    || (pc_in_boot && !vector_select_bit && boot_lock_field); // [RULE_09]
  // CLI in the same cycle already blocks
  assign take_ok = irq.req && gie_ff && !cli_now
                   && !lock_block; // [RULE_08] [RULE_13] [RULE_21]
  // Taking at a boundary means after that instruction ran
  assign take_run = take_ok && boundary && !flow_op; // [RULE_19] [RULE_22]
  assign take_sleep = take_ok && in_run && sleeping && !instr_valid
                      && !hold_ff; // [RULE_19] [RULE_22]
  assign take = take_run || take_sleep;
  assign irq.take = take;
  assign irq.take_idx = irq.req_idx;

  assign vec_base = vector_select_bit ? csis_pkg::BOOT_START
                                      : csis_pkg::RESET_VEC; // [RULE_11]
  assign vec_addr = vec_base
    + PW'((PW'(irq.req_idx) + PW'(1)) << csis_pkg::VEC_SHIFT); // [RULE_10]

  // ==========================================================
  // Sequencer
  logic entry_wr;
  logic ret_rd;
  logic seq_end;

  assign entry_wr = (state_ff == csis_pkg::ST_ENTRY)
                    && cnt_ff < csis_pkg::PUSH_BYTES;
  assign ret_rd = (state_ff == csis_pkg::ST_RET)
                  && cnt_ff < csis_pkg::PUSH_BYTES;
  assign seq_end = (cnt_ff == csis_pkg::ENTRY_LAST);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      csis_pkg::ST_RUN: begin
        if (take_sleep) begin
          nxt_state = csis_pkg::ST_WAKE; // [RULE_23]
        end else if (take_run || do_call) begin
          nxt_state = csis_pkg::ST_ENTRY;
        end else if (do_ret || do_iret) begin
          nxt_state = csis_pkg::ST_RET;
        end
      end
      csis_pkg::ST_WAKE: begin
        if (cnt_ff == csis_pkg::WAKE_LAST) begin
          nxt_state = csis_pkg::ST_ENTRY;
        end
      end
      csis_pkg::ST_ENTRY: begin
        if (seq_end) begin
          nxt_state = csis_pkg::ST_RUN;
        end
      end
      csis_pkg::ST_RET: begin
        if (cnt_ff == csis_pkg::RET_LAST) begin
          nxt_state = csis_pkg::ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_ff <= csis_pkg::ST_RUN;
      cnt_ff <= 2'h0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= (nxt_state != state_ff) ? 2'h0 : cnt_ff + 2'h1; // [RULE_23]
    end
  end

  // ==========================================================
  // Stack pointer and stack port
  logic io_sp_lo;
  logic io_sp_hi;
  logic sp_dec;
  logic sp_inc;
  logic [SW-1:0] sp_plus1;
  logic [SW-1:0] nxt_sp;
  logic [15:0] ret_pc16;
  logic [7:0] nxt_wdata;
  logic [7:0] rd_mux;

  assign io_sp_lo = io_wr && io_addr == csis_pkg::SP_LO_ADDR;
  assign io_sp_hi = io_wr && io_addr == csis_pkg::SP_HI_ADDR;
  assign sp_dec = do_push || entry_wr; // [RULE_01] [RULE_02]
  assign sp_inc = do_pop || ret_rd; // [RULE_01] [RULE_02] [RULE_24]
  assign sp_plus1 = sp_ff + SW'(1);
  // Upper high-byte bits are simply not stored
  assign nxt_sp = io_sp_lo ? {sp_ff[SW-1:8], io_wdata}
    : io_sp_hi ? {io_wdata[csis_pkg::SP_HI_BITS-1:0], sp_ff[7:0]} // [RULE_26]
    : sp_dec ? sp_ff - SW'(1)
    : sp_inc ? sp_plus1 : sp_ff; // [RULE_03]
  assign ret_pc16 = 16'(ret_pc_ff);
  // Low byte goes to the higher address so pops see high byte first
  assign nxt_wdata = do_push ? instr_data
    : (cnt_ff == 2'h0) ? ret_pc16[7:0] : ret_pc16[15:8];
  assign rd_mux = (io_addr == csis_pkg::SP_LO_ADDR) ? sp_ff[7:0]
    : (io_addr == csis_pkg::SP_HI_ADDR) ? 8'(sp_ff[SW-1:8]) // [RULE_26]
    : 8'h00;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sp_ff <= csis_pkg::SP_RST; // [RULE_04]
      stk_we_ff <= 1'b0;
      stk_rd_ff <= 1'b0;
      stk_addr_ff <= '0;
      stk_wdata_ff <= 8'h00;
      io_rdata_ff <= 8'h00;
    end else begin
      sp_ff <= nxt_sp;
      stk_we_ff <= do_push || entry_wr; // [RULE_01]
      stk_rd_ff <= do_pop || ret_rd;
      stk_addr_ff <= (do_pop || ret_rd) ? sp_plus1 : sp_ff;
      stk_wdata_ff <= nxt_wdata;
      io_rdata_ff <= io_rd ? rd_mux : 8'h00; // [RULE_03]
    end
  end

  // ==========================================================
  // Program counter, global enable
  logic ret_done;
  logic [PW-1:0] popped_pc;

  assign ret_done = (state_ff == csis_pkg::ST_RET)
                    && cnt_ff == csis_pkg::RET_LAST;
  assign popped_pc = PW'({hi_ff, stk_rdata});

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pc_ff <= boot_reset_fuse ? csis_pkg::BOOT_START
                               : csis_pkg::RESET_VEC; // [RULE_11]
      ret_pc_ff <= '0;
      target_ff <= '0;
      hi_ff <= 8'h00;
      is_irq_ff <= 1'b0;
      hold_ff <= 1'b0;
      gie_ff <= 1'b0;
    end else begin
      if (take || do_call) begin
        ret_pc_ff <= pc_ff;
        target_ff <= take ? vec_addr : instr_target;
        is_irq_ff <= take;
      end else if (do_ret || do_iret) begin
        is_irq_ff <= do_iret;
      end
      if ((state_ff == csis_pkg::ST_RET) && cnt_ff == 2'h2) begin
        hi_ff <= stk_rdata;
      end
      if (ret_done) begin
        pc_ff <= popped_pc;
      end else if ((state_ff == csis_pkg::ST_ENTRY) && seq_end) begin
        pc_ff <= target_ff;
      end else if (in_run && instr_valid && !take && !flow_op) begin
        pc_ff <= pc_ff + PW'(1); // [RULE_07]
      end
      // One main instruction must run before a sleeping take
      if ((ret_done && is_irq_ff) || do_sei) begin
        hold_ff <= 1'b1; // [RULE_19] [RULE_22]
      end else if (boundary) begin
        hold_ff <= 1'b0;
      end
      if (take) begin
        gie_ff <= 1'b0; // [RULE_12]
      end else if (ret_done && is_irq_ff) begin
        gie_ff <= 1'b1; // [RULE_14] [RULE_24]
      end else if (do_sei) begin
        gie_ff <= 1'b1; // [RULE_13]
      end else if (cli_now) begin
        gie_ff <= 1'b0; // [RULE_21]
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
      fetch_pc_ff <= '0;
    end else begin
      busy_ff <= (nxt_state != csis_pkg::ST_RUN);
      fetch_pc_ff <= pc_ff; // [RULE_07]
    end
  end

  // ==========================================================
  // ALU and register file
  logic [7:0] opa;
  logic [7:0] opb;
  logic [7:0] alu_res;

  assign opa = rf[alu_rd];
  assign opb = alu_use_imm ? alu_imm : rf[alu_rr];
  assign alu_res = (alu_fn == csis_pkg::ALU_ADD) ? opa + opb
    : (alu_fn == csis_pkg::ALU_SUB) ? opa - opb
    : (alu_fn == csis_pkg::ALU_AND) ? opa & opb
    : (alu_fn == csis_pkg::ALU_OR) ? opa | opb
    : (alu_fn == csis_pkg::ALU_XOR) ? opa ^ opb : opb;

  // Data array, no reset: software loads it
  always_ff @(posedge mclk) begin
    if (do_alu) begin
      rf[alu_rd] <= alu_res; // [RULE_05]
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      alu_result_ff <= 8'h00;
    end else if (do_alu) begin
      alu_result_ff <= alu_res; // [RULE_05]
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_entry;
    state_ff == csis_pkg::ST_ENTRY [*4] ##1 state_ff == csis_pkg::ST_RUN;
  endsequence

  sequence s_wake;
    state_ff == csis_pkg::ST_WAKE [*4];
  endsequence

  a_push_dec_one: assert property ((do_push && !io_wr) // [RULE_01]
    |=> sp_ff == $past(sp_ff) - 11'h001)
    else $error("push did not lower pointer by one");

  a_pop_inc_one: assert property ((do_pop && !io_wr) // [RULE_01]
    |=> sp_ff == $past(sp_ff) + 11'h001)
    else $error("pop did not raise pointer by one");

  // Second decrement lands on the third edge after the take
  a_entry_sp_two: assert property ( // [RULE_02]
    (take_run && !io_wr && !do_push && !do_pop) ##1 !io_wr [*2]
    |=> sp_ff == $past(sp_ff, 3) - 11'h002)
    else $error("entry did not lower pointer by two");

  a_entry_four_cycles: assert property (take_run |=> s_entry) // [RULE_23]
    else $error("interrupt entry not four cycles");

  a_wake_extra_four: assert property ( // [RULE_23]
    take_sleep |=> s_wake ##1 s_entry)
    else $error("wake entry not eight cycles");

  a_take_needs_gie: assert property ( // [RULE_08] [RULE_12] [RULE_21]
    take |-> gie_ff && !cli_now ##1 !gie_ff)
    else $error("interrupt taken without enable or gie kept");

  a_iret_sets_gie: assert property (do_iret ##1 // [RULE_14] [RULE_24]
    state_ff == csis_pkg::ST_RET [*4] |=> gie_ff)
    else $error("return did not set gie");

  a_sp_hi_zero: assert property ( // [RULE_26]
    (io_rd && io_addr == csis_pkg::SP_HI_ADDR) |=> io_rdata_ff[7:3] == 5'h00)
    else $error("unused pointer bits read nonzero");

  a_alu_one_cycle: assert property (do_alu // [RULE_05]
    |=> alu_result_ff == $past(alu_res))
    else $error("alu result not in one cycle");

endmodule : csis_core_seq

//--- csis_irq_bank.sv
`timescale 1ns/1ps
module csis_irq_bank #(
  parameter int N_SRC = 8,
  parameter int IDX_W = 3
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [N_SRC-1:0] flag_evt,
  input wire logic [N_SRC-1:0] level_type,
  input wire logic [N_SRC-1:0] level_req,
  input wire logic [N_SRC-1:0] src_enable,
  input wire logic flag_clr_wr,
  input wire logic [N_SRC-1:0] flag_clr_data,
  csis_irq_if.bank irq
);

  logic [N_SRC-1:0] flags_ff;
  logic [N_SRC-1:0] nxt_flags;
  logic [N_SRC-1:0] sw_clr;
  logic [N_SRC-1:0] hw_clr;
  logic [N_SRC-1:0] pend;
  logic [IDX_W-1:0] first_idx;

  // ==========================================================
  // Flags
  assign sw_clr = flag_clr_wr ? flag_clr_data : '0; // [RULE_16]
  assign hw_clr = irq.take ? (N_SRC'(1) << irq.take_idx) & ~level_type
                           : '0; // [RULE_15]
  // Event in the clearing cycle survives the clear
  assign nxt_flags = (flags_ff & ~sw_clr & ~hw_clr) | (flag_evt & ~level_type);

  // Level sources only request while their condition holds
  assign pend = ((level_type & level_req) | (~level_type & flags_ff))
                & src_enable; // [RULE_08] [RULE_17] [RULE_18]

  // Lowest index wins
  always_comb begin // [RULE_10]
    first_idx = '0;
    for (int i = N_SRC - 1; i >= 0; i--) begin
      if (pend[i]) begin
        first_idx = IDX_W'(i);
      end
    end
  end

  assign irq.req = |pend;
  assign irq.req_idx = first_idx;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      flags_ff <= '0;
    end else begin
      flags_ff <= nxt_flags; // [RULE_17]
    end
  end

  // ==========================================================
  // Checks
  a_flag_set_wins: assert property ( // [RULE_17]
    @(posedge mclk) disable iff (!rst_n)
    (flag_evt[0] && !level_type[0]) |=> flags_ff[0])
    else $error("flag event lost against a clear");

  a_take_clears_flag: assert property ( // [RULE_15]
    @(posedge mclk) disable iff (!rst_n)
    (irq.take && irq.take_idx == '0 && !level_type[0] && !flag_evt[0])
    |=> !flags_ff[0])
    else $error("taken flag not cleared");

endmodule : csis_irq_bank

//--- csis_irq_if.sv
`timescale 1ns/1ps
interface csis_irq_if #(
  parameter int N_SRC = 8,
  parameter int IDX_W = 3
);
  logic req;
  logic [IDX_W-1:0] req_idx;
  logic take;
  logic [IDX_W-1:0] take_idx;

  modport bank (output req, output req_idx, input take, input take_idx);
  modport seq (input req, input req_idx, output take, output take_idx);
endinterface : csis_irq_if

//--- csis_pkg.sv
package csis_pkg;

  // ==========================================================
  // I/O map of the stack pointer
  localparam logic [5:0] SP_LO_ADDR = 6'h3d;
  localparam logic [5:0] SP_HI_ADDR = 6'h3e;
  localparam int SP_W = 11;
  localparam int SP_HI_BITS = 3;
  localparam logic [7:0] SP_LO_RST = 8'h00;
  localparam logic [7:0] SP_HI_RST = 8'h00;
  // Start value of the pointer itself: last SRAM word
  localparam logic [10:0] SP_RST = 11'h7ff;

  // ==========================================================
  // Program counter and vectors
  localparam int PC_W = 13;
  localparam logic [12:0] RESET_VEC = 13'h0000;
  localparam logic [12:0] BOOT_START = 13'h1000;
  localparam int VEC_SHIFT = 1;

  // ==========================================================
  // Cycle counts
  localparam logic [1:0] ENTRY_LAST = 2'h3;
  localparam logic [1:0] WAKE_LAST = 2'h3;
  localparam logic [1:0] RET_LAST = 2'h3;
  localparam logic [1:0] PUSH_BYTES = 2'h2;

  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    OP_NONE, OP_ALU, OP_PUSH, OP_POP, OP_CALL, OP_RET, OP_IRET,
    OP_SEI, OP_CLI
  } csis_op_t;

  typedef enum logic [2:0] {
    ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_MOV
  } csis_alu_t;

  typedef enum logic [1:0] {
    ST_RUN, ST_WAKE, ST_ENTRY, ST_RET
  } csis_state_t;

endpackage : csis_pkg

//--- csis_stack_mem.sv
`timescale 1ns/1ps
// ==========================================================
// Data memory behind the stack port
module csis_stack_mem (
  input wire logic mclk,
  input wire logic stk_we,
  input wire logic stk_rd,
  input wire logic [10:0] stk_addr,
  input wire logic [7:0] stk_wdata,
  output logic [7:0] stk_rdata
);
  logic [7:0] mem [0:2047];

  initial stk_rdata = 8'h00;

  always @(posedge mclk) begin
    if (stk_we) begin
      mem[stk_addr] <= stk_wdata;
    end
    // Byte valid one cycle only; idle bus toggles so stale data shows
    if (stk_rd) begin
      stk_rdata <= mem[stk_addr];
    end else begin
      stk_rdata <= ~stk_rdata;
    end
  end
endmodule : csis_stack_mem

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic mclk = 1'b0;
  logic rst_n, io_wr, io_rd, instr_valid, instr_last, alu_use_imm;
  logic vector_select_bit, boot_reset_fuse, flag_clr_wr, sleeping;
  logic busy_ff, gie_ff, stk_we_ff, stk_rd_ff;
  logic [5:0] io_addr;
  logic [7:0] io_wdata, io_rdata_ff, instr_data, alu_imm, stk_wdata_ff;
  logic [7:0] stk_rdata, alu_result_ff, flag_evt, src_enable, flag_clr_data;
  logic [12:0] instr_target, fetch_pc_ff, rpc;
  logic [4:0] alu_rd, alu_rr;
  logic [10:0] stk_addr_ff, sp;
  csis_pkg::csis_op_t instr_op;
  csis_pkg::csis_alu_t alu_fn;
  logic rd_prev = 1'b0;
  logic alu_prev = 1'b0;
  logic [20:0] notes[$];
  logic [20:0] ex, sn;
  logic [7:0] a8, b8, r8;
  int compares = 0;
  int n_mismatch = 0;
  int a;

  always #20 mclk = ~mclk;

  csis_core_seq i_csis_core_seq (
    .mclk, .rst_n, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata_ff,
    .instr_valid, .instr_last, .instr_op, .instr_data, .instr_target,
    .alu_fn, .alu_rd, .alu_rr, .alu_imm, .alu_use_imm,
    .sleeping, .vector_select_bit, .boot_reset_fuse,
    .app_lock_field(1'b0), .boot_lock_field(1'b0), .flag_evt,
    .level_type(8'h00), .level_req(8'h00), .src_enable, .flag_clr_wr,
    .flag_clr_data, .fetch_pc_ff, .busy_ff, .gie_ff, .stk_we_ff,
    .stk_rd_ff, .stk_addr_ff, .stk_wdata_ff, .stk_rdata, .alu_result_ff
  );

  csis_stack_mem i_csis_stack_mem (
    .mclk, .stk_we(stk_we_ff), .stk_rd(stk_rd_ff), .stk_addr(stk_addr_ff),
    .stk_wdata(stk_wdata_ff), .stk_rdata
  );

  task automatic print_verdict;
    if (notes.size() != 0) begin
      n_mismatch++;
      $display("CHECK FAILED notes_left expected 0 seen %0d", notes.size());
    end
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  task automatic cmp(input string nm, input logic [20:0] e,
      input logic [20:0] s);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp

  // ==========================================================
  // Result monitor: each result takes the oldest note
  always @(posedge mclk) begin
    rd_prev <= io_rd;
    alu_prev <= instr_valid && !busy_ff && instr_op == csis_pkg::OP_ALU;
  end

  always @(negedge mclk) begin
    if (rst_n && (rd_prev || alu_prev || stk_we_ff === 1'b1)) begin
      if (notes.size() == 0) begin
        cmp("unexpected_result", 21'(0), 21'(1));
      end else begin
        ex = notes.pop_front();
        case (ex[20:19])
          2'd0: sn = {2'd0, 11'h000, io_rdata_ff};
          2'd1: sn = {2'd1, stk_addr_ff, stk_wdata_ff};
          2'd2: sn = {2'd2, stk_addr_ff, 8'h00};
          default: sn = {2'd3, 11'h000, alu_result_ff};
        endcase
        cmp("result", ex, sn);
      end
    end
  end

  // ==========================================================
  // Drivers, all changing inputs at the falling edge
  task automatic io_acc(input logic w, input logic [5:0] ad,
      input logic [7:0] d, input logic [7:0] e);
    @(negedge mclk);
    io_addr = ad;
    io_wdata = d;
    io_wr = w;
    io_rd = !w;
    if (!w) begin
      notes.push_back({2'd0, 11'h000, e});
    end
    @(negedge mclk);
    io_wr = 1'b0;
    io_rd = 1'b0;
  endtask : io_acc

  task automatic chk_sp(input logic [10:0] e);
    io_acc(1'b0, csis_pkg::SP_LO_ADDR, 8'h00, e[7:0]);
    io_acc(1'b0, csis_pkg::SP_HI_ADDR, 8'h00, {5'h00, e[10:8]});
  endtask : chk_sp

  task automatic exec(input csis_pkg::csis_op_t op, input logic [7:0] d,
      input logic [7:0] f);
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (busy_ff !== 1'b0 && n < 20);
    if (n >= 20) begin
      cmp("idle_wait", 21'(0), 21'(n));
      print_verdict();
    end
    instr_op = op;
    instr_data = d;
    flag_evt = f;
    instr_valid = 1'b1;
    instr_last = 1'b1;
    @(negedge mclk);
    instr_valid = 1'b0;
    instr_last = 1'b0;
    flag_evt = 8'h00;
  endtask : exec

  task automatic wait_busy;
    int n;
    n = 0;
    while (busy_ff === 1'b1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    cmp("busy_cycles", 21'(4), 21'(n));
    if (n >= 20) begin
      print_verdict();
    end
  endtask : wait_busy

  task automatic pc_is(input logic [12:0] e);
    int n;
    n = 0;
    while (fetch_pc_ff !== e && n < 3) begin
      @(negedge mclk);
      n++;
    end
    cmp("fetch_pc", 21'(e), 21'(fetch_pc_ff));
  endtask : pc_is

  // Return address unknown here, so only stack addresses are noted
  task automatic enter(input csis_pkg::csis_op_t op, input logic [12:0] v);
    notes.push_back({2'd2, sp, 8'h00});
    notes.push_back({2'd2, sp - 11'd1, 8'h00});
    exec(op, 8'h00, 8'h00);
    cmp("busy", 21'(1), 21'(busy_ff));
    wait_busy();
    pc_is(v);
    chk_sp(sp - 11'd2);
    rpc = {i_csis_stack_mem.mem[sp - 11'd1][4:0],
           i_csis_stack_mem.mem[sp]};
  endtask : enter

  task automatic leave(input csis_pkg::csis_op_t op);
    exec(op, 8'h00, 8'h00);
    wait_busy();
    pc_is(rpc);
    chk_sp(sp);
  endtask : leave

  task automatic alu(input int f, input logic [4:0] d, input logic [4:0] s,
      input logic [7:0] im, input logic [7:0] e);
    alu_fn = csis_pkg::csis_alu_t'(f);
    alu_rd = d;
    alu_rr = s;
    alu_imm = im;
    alu_use_imm = (s == 5'd0);
    notes.push_back({2'd3, 11'h000, e});
    exec(csis_pkg::OP_ALU, 8'h00, 8'h00);
  endtask : alu

  function automatic logic [7:0] fn(input int f, input logic [7:0] x,
      input logic [7:0] y);
    case (f)
      0: return x + y;
      1: return x - y;
      2: return x & y;
      3: return x | y;
      default: return x ^ y;
    endcase
  endfunction : fn

  function automatic logic [12:0] vec(input int i);
    logic [12:0] base;
    base = vector_select_bit ? csis_pkg::BOOT_START : 13'h0000;
    return base + 13'((i + 1) << csis_pkg::VEC_SHIFT);
  endfunction : vec

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(72292));
    {rst_n, io_wr, io_rd, instr_valid, instr_last, alu_use_imm} = '0;
    {flag_clr_wr, vector_select_bit, sleeping, flag_evt, src_enable} = '0;
    {io_addr, io_wdata, instr_data, alu_imm, instr_target} = '0;
    {alu_rd, alu_rr, flag_clr_data} = '0;
    instr_op = csis_pkg::OP_NONE;
    alu_fn = csis_pkg::ALU_ADD;
    boot_reset_fuse = 1'($urandom);
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    pc_is(boot_reset_fuse ? csis_pkg::BOOT_START : 13'h0000);
    chk_sp(csis_pkg::SP_RST);
    io_acc(1'b1, 6'h3f, 8'hff, 8'h00);
    io_acc(1'b0, 6'h3f, 8'h00, 8'h00);
    a8 = 8'($urandom);
    io_acc(1'b1, csis_pkg::SP_HI_ADDR, 8'hff, 8'h00);
    io_acc(1'b1, csis_pkg::SP_LO_ADDR, a8, 8'h00);
    chk_sp({3'h7, a8});
    sp = {3'h4, 8'($urandom)};
    io_acc(1'b1, csis_pkg::SP_HI_ADDR, {5'h00, sp[10:8]}, 8'h00);
    io_acc(1'b1, csis_pkg::SP_LO_ADDR, sp[7:0], 8'h00);
    a8 = 8'($urandom);
    notes.push_back({2'd1, sp, a8});
    exec(csis_pkg::OP_PUSH, a8, 8'h00);
    chk_sp(sp - 11'd1);
    exec(csis_pkg::OP_POP, 8'h00, 8'h00);
    chk_sp(sp);
    instr_target = 13'($urandom);
    enter(csis_pkg::OP_CALL, instr_target);
    leave(csis_pkg::OP_RET);
    for (int f = 0; f < 5; f++) begin
      a8 = 8'($urandom);
      b8 = 8'($urandom);
      r8 = fn(f, a8, b8);
      alu(5, 5'd1, 5'd0, a8, a8);
      alu(5, 5'd2, 5'd0, b8, b8);
      alu(f, 5'd1, 5'd2, 8'h00, r8);
      alu(f, 5'd1, 5'd0, b8, fn(f, r8, b8));
    end
    // Sources a and a+2 live, a+1 cleared by software, a+4 disabled
    vector_select_bit = 1'($urandom);
    a = $urandom_range(3);
    src_enable = 8'h07 << a;
    exec(csis_pkg::OP_NONE, 8'h00, 8'h17 << a);
    exec(csis_pkg::OP_NONE, 8'h00, 8'h00);
    cmp("busy", 21'(0), 21'(busy_ff));
    @(negedge mclk);
    flag_clr_wr = 1'b1;
    flag_clr_data = 8'h02 << a;
    @(negedge mclk);
    flag_clr_wr = 1'b0;
    exec(csis_pkg::OP_SEI, 8'h00, 8'h00);
    cmp("gie", 21'(1), 21'(gie_ff));
    cmp("busy", 21'(0), 21'(busy_ff));
    enter(csis_pkg::OP_NONE, vec(a));
    cmp("gie", 21'(0), 21'(gie_ff));
    leave(csis_pkg::OP_IRET);
    cmp("gie", 21'(1), 21'(gie_ff));
    enter(csis_pkg::OP_NONE, vec(a + 2));
    leave(csis_pkg::OP_IRET);
    // Source a pends here, so the disable below has a take to block
    exec(csis_pkg::OP_NONE, 8'h00, 8'h01 << a);
    cmp("busy", 21'(0), 21'(busy_ff));
    exec(csis_pkg::OP_CLI, 8'h00, 8'h01 << a);
    cmp("gie", 21'(0), 21'(gie_ff));
    cmp("busy", 21'(0), 21'(busy_ff));
    exec(csis_pkg::OP_NONE, 8'h00, 8'h00);
    cmp("busy", 21'(0), 21'(busy_ff));
    exec(csis_pkg::OP_SEI, 8'h00, 8'h00);
    enter(csis_pkg::OP_NONE, vec(a));
    leave(csis_pkg::OP_IRET);
    // Wake from sleep: four extra cycles before the entry
    exec(csis_pkg::OP_NONE, 8'h00, 8'h00);
    notes.push_back({2'd2, sp, 8'h00});
    notes.push_back({2'd2, sp - 11'd1, 8'h00});
    {sleeping, flag_evt} = {1'b1, 8'h01 << a};
    @(negedge mclk);
    flag_evt = 8'h00;
    repeat (10) @(negedge mclk);
    sleeping = 1'b0;
    pc_is(vec(a));
    rpc = {i_csis_stack_mem.mem[sp - 11'd1][4:0],
           i_csis_stack_mem.mem[sp]};
    leave(csis_pkg::OP_IRET);
    repeat (2) @(negedge mclk);
    print_verdict();
  end
endmodule : tb_top
